// ---- design/pattern_gen_map.svh ----
// Constants of the serial-link test-pattern generator: selection codes,
// fixed characters and pattern lengths.
// Assumes it is included by bare name from the design files only.
`ifndef PATTERN_GEN_MAP_SVH
`define PATTERN_GEN_MAP_SVH

// Selection codes of test_pattern_select
`define TPG_SEL_NORMAL    3'h0
`define TPG_SEL_TRANSPORT 3'h1
`define TPG_SEL_D215      3'h2
`define TPG_SEL_K285      3'h3
`define TPG_SEL_REP_ILAS  3'h4
`define TPG_SEL_RPAT      3'h5

// Fixed characters, before encoding
`define TPG_D215_OCTET    8'hB5
`define TPG_K285_OCTET    8'hBC

// Pattern lengths and lanes per bank
`define TPG_N12_FRAME_OCT 4'h8
`define TPG_RPAT_LEN      4'hC
`define TPG_BANK_LANES    5'h08

// Modified RPAT octets in send order
`define TPG_RPAT_0        8'hBE
`define TPG_RPAT_1        8'hD7
`define TPG_RPAT_2        8'h23
`define TPG_RPAT_3        8'h47
`define TPG_RPAT_4        8'h6B
`define TPG_RPAT_5        8'h8F
`define TPG_RPAT_6        8'hB3
`define TPG_RPAT_7        8'h14
`define TPG_RPAT_8        8'h5E
`define TPG_RPAT_9        8'hFB
`define TPG_RPAT_10       8'h35
`define TPG_RPAT_11       8'h59

`endif

// ---- design/pattern_gen_pkg.sv ----
// Types shared by the test-pattern generator and its lane slice.
// Assumes nothing of its surroundings.
package pattern_gen_pkg;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_TRANSPORT,
        MODE_D215,
        MODE_K285,
        MODE_REP_ILAS,
        MODE_RPAT
    } mode_t;

    // One lane octet towards the encoder; ctrl marks a control character
    typedef struct packed {
        logic [7:0] data;
        logic       ctrl;
    } lane_octet_t;

endpackage

// ---- design/lane_pattern.sv ----
// One lane slice: picks the octet that a lane sends for the active mode.
// Assumes the caller supplies frame position and registers the result.
`include "pattern_gen_map.svh"

module lane_pattern #(
    parameter int LANE_IDX = 0
) (
    // Mode and frame position
    input  wire pattern_gen_pkg::mode_t       mode,
    input  wire logic                         sampleIs12,
    input  wire logic [3:0]                   octetIdx,
    input  wire logic                         frameOdd,
    input  wire logic [7:0]                   rpatOctet,
    // Data
    input  wire pattern_gen_pkg::lane_octet_t normIn,
    output pattern_gen_pkg::lane_octet_t      laneOut
);

    // Bank B lanes repeat bank A lanes
    localparam logic [3:0] LANE_M = 4'(LANE_IDX % `TPG_BANK_LANES);

    function automatic logic [3:0] nibble12(input logic [3:0] n);
        logic [3:0] word;
        logic [1:0] pos;
        word = 4'(n / 4'h3);
        pos  = 2'(n % 4'h3);
        if (n == 4'hF) begin
            nibble12 = 4'h0; // R17
        end else if (pos == 2'h0) begin
            nibble12 = 4'hF - LANE_M; // R7
        end else if (pos == 2'h1) begin
            nibble12 = LANE_M;
        end else begin
            nibble12 = word + 4'h1;
        end
    endfunction

    logic [7:0] shortOctet;
    logic [3:0] hiNib;

    always_comb begin
        hiNib = 4'({octetIdx[2:0], 1'b0});
        if (sampleIs12) begin
            shortOctet = {nibble12(hiNib), nibble12(hiNib + 4'h1)}; // R7
        end else begin
            shortOctet = {6'h00, LANE_M[1:0]} ^ {8{frameOdd}}; // R5
        end
    end

    always_comb begin
        laneOut = normIn;
        unique case (mode)
            pattern_gen_pkg::MODE_TRANSPORT: begin
                laneOut = '{data: shortOctet, ctrl: 1'b0}; // R4 R1
            end
            pattern_gen_pkg::MODE_D215: begin
                laneOut = '{data: `TPG_D215_OCTET, ctrl: 1'b0}; // R8
            end
            pattern_gen_pkg::MODE_K285: begin
                laneOut = '{data: `TPG_K285_OCTET, ctrl: 1'b1}; // R9
            end
            pattern_gen_pkg::MODE_RPAT: begin
                laneOut = '{data: rpatOctet, ctrl: 1'b0}; // R12
            end
            pattern_gen_pkg::MODE_NORMAL,
            pattern_gen_pkg::MODE_REP_ILAS: begin
                laneOut = normIn;
            end
        endcase
    end

endmodule

// ---- design/serial_link_test_pattern_gen.sv ----
// Test-pattern generator in front of the lane encoders of the serial link.
// Assumes the link layer reports its state and accepts one octet per lane
// per clk_sys cycle when ce is high; all inputs are synchronous to clk_sys.
`include "pattern_gen_map.svh"

// What this block does
// R1: Same transport pattern for either encoding
// R2: 8b/10b: pattern after alignment, during data state
// R3: 64b/66b: pattern once serializers initialised
// R4: Short transport pattern, repeated every two frames
// R5: 8-bit: frame0 lane k mod 4, frame1 inverted
// R6: Only lowest enabled lanes carry the pattern
// R7: 12-bit words: F minus m, m, j
// R8: D21.5 stream, either encoding
// R9: K28.5 stream, 8b/10b only
// R10: Alignment sequence repeats, no data phase
// R11: Sync request triggers code group sync
// R12: Twelve-octet jitter pattern, 8b/10b only
// R13: Jitter pattern octet order fixed
// R14: Selection field picks mode; none means normal
// R15: Selection changes only while link disabled
// R16: Powered lanes follow link mode
// R17: Last nibble of 12-bit frame zero
// R18: Unsupported selection sends normal data
module serial_link_test_pattern_gen #(
    parameter int NUM_LANES = 16
) (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst_b,
    input  wire logic                         ce,
    // Configuration
    input  wire logic [2:0]                   testPatternSelect,
    input  wire logic                         linkEnable,
    input  wire logic                         enc64b66b,
    input  wire logic                         sampleIs12,
    input  wire logic [3:0]                   frameOctets,
    input  wire logic [4:0]                   linkModeLanes,
    // Link layer state
    input  wire logic                         linkInDataEnc,
    input  wire logic                         serInitDone,
    input  wire logic                         syncRequest,
    // Normal data from the transport layer
    input  wire pattern_gen_pkg::lane_octet_t normLane [NUM_LANES],
    // Lane data towards the encoders
    output pattern_gen_pkg::lane_octet_t      txLane   [NUM_LANES],
    output logic [NUM_LANES-1:0]              laneOn,
    // Link layer control
    output logic                              ilasRepeat,
    output logic                              codeGroupSync,
    output logic                              patternActive
);

    // Lane index compare is five bits wide and would serve 31 lanes; this check allows at most 16
    if (NUM_LANES < 1 || NUM_LANES > 16) begin : gBadLanes
        $error("NUM_LANES must lie between 1 and 16");
    end

    // Mode selection, held while the link runs
    pattern_gen_pkg::mode_t selMode_ff;
    pattern_gen_pkg::mode_t nxt_selMode;
    pattern_gen_pkg::mode_t effMode;
    logic                   patternGo;

    always_comb begin
        nxt_selMode = selMode_ff;
        // Sampling only while the link is off keeps a pattern from being cut mid-frame
        if (!linkEnable) begin // R15
            unique case (testPatternSelect) // R14
                `TPG_SEL_TRANSPORT: nxt_selMode = pattern_gen_pkg::MODE_TRANSPORT;
                `TPG_SEL_D215:      nxt_selMode = pattern_gen_pkg::MODE_D215;
                `TPG_SEL_K285:      nxt_selMode = pattern_gen_pkg::MODE_K285;
                `TPG_SEL_REP_ILAS:  nxt_selMode = pattern_gen_pkg::MODE_REP_ILAS;
                `TPG_SEL_RPAT:      nxt_selMode = pattern_gen_pkg::MODE_RPAT;
                default:            nxt_selMode = pattern_gen_pkg::MODE_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            selMode_ff <= pattern_gen_pkg::MODE_NORMAL;
        end else if (ce) begin
            selMode_ff <= nxt_selMode;
        end
    end

    // Effective mode: unsupported choices and not-yet-started patterns send normal data
    always_comb begin
        patternGo = enc64b66b ? serInitDone : linkInDataEnc; // R2 R3
        effMode   = pattern_gen_pkg::MODE_NORMAL;
        if (linkEnable) begin
            unique case (selMode_ff)
                pattern_gen_pkg::MODE_TRANSPORT: begin
                    if (patternGo) begin
                        effMode = pattern_gen_pkg::MODE_TRANSPORT; // R1
                    end
                end
                pattern_gen_pkg::MODE_D215: begin
                    effMode = pattern_gen_pkg::MODE_D215; // R8
                end
                pattern_gen_pkg::MODE_K285,
                pattern_gen_pkg::MODE_REP_ILAS,
                pattern_gen_pkg::MODE_RPAT: begin
                    if (!enc64b66b) begin
                        effMode = selMode_ff; // R9 R10 R12
                    end else begin
                        effMode = pattern_gen_pkg::MODE_NORMAL; // R18
                    end
                end
                pattern_gen_pkg::MODE_NORMAL: begin
                    effMode = pattern_gen_pkg::MODE_NORMAL;
                end
            endcase
        end
    end

    // Frame position counters
    logic [3:0] octetIdx_ff;
    logic [3:0] nxt_octetIdx;
    logic       frameOdd_ff;
    logic       nxt_frameOdd;
    logic [3:0] rpatIdx_ff;
    logic [3:0] nxt_rpatIdx;
    logic [3:0] frameLast;

    always_comb begin
        if (sampleIs12) begin
            frameLast = `TPG_N12_FRAME_OCT - 4'h1;
        end else if (frameOctets == 4'h0) begin
            frameLast = 4'h0;
        end else begin
            frameLast = frameOctets - 4'h1;
        end
        nxt_octetIdx = 4'h0;
        nxt_frameOdd = 1'b0;
        nxt_rpatIdx  = 4'h0;
        // Restarting from frame 0 each time keeps frame 0 first after alignment
        if (effMode == pattern_gen_pkg::MODE_TRANSPORT) begin
            if (octetIdx_ff == frameLast) begin
                nxt_frameOdd = ~frameOdd_ff; // R4
            end else begin
                nxt_octetIdx = octetIdx_ff + 4'h1;
                nxt_frameOdd = frameOdd_ff;
            end
        end
        if (effMode == pattern_gen_pkg::MODE_RPAT) begin
            if (rpatIdx_ff != `TPG_RPAT_LEN - 4'h1) begin
                nxt_rpatIdx = rpatIdx_ff + 4'h1; // R13
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            octetIdx_ff <= 4'h0;
            frameOdd_ff <= 1'b0;
            rpatIdx_ff  <= 4'h0;
        end else if (ce) begin
            octetIdx_ff <= nxt_octetIdx;
            frameOdd_ff <= nxt_frameOdd;
            rpatIdx_ff  <= nxt_rpatIdx;
        end
    end

    // Jitter pattern octet, same on every lane
    logic [7:0] rpatOctet;

    always_comb begin
        unique case (rpatIdx_ff) // R13
            4'h0:    rpatOctet = `TPG_RPAT_0;
            4'h1:    rpatOctet = `TPG_RPAT_1;
            4'h2:    rpatOctet = `TPG_RPAT_2;
            4'h3:    rpatOctet = `TPG_RPAT_3;
            4'h4:    rpatOctet = `TPG_RPAT_4;
            4'h5:    rpatOctet = `TPG_RPAT_5;
            4'h6:    rpatOctet = `TPG_RPAT_6;
            4'h7:    rpatOctet = `TPG_RPAT_7;
            4'h8:    rpatOctet = `TPG_RPAT_8;
            4'h9:    rpatOctet = `TPG_RPAT_9;
            4'hA:    rpatOctet = `TPG_RPAT_10;
            4'hB:    rpatOctet = `TPG_RPAT_11;
            default: rpatOctet = `TPG_RPAT_0;
        endcase
    end

    // Lane slices and output registers
    pattern_gen_pkg::lane_octet_t laneNext [NUM_LANES];
    pattern_gen_pkg::lane_octet_t txLane_ff [NUM_LANES];
    pattern_gen_pkg::lane_octet_t nxt_txLane [NUM_LANES];
    logic [NUM_LANES-1:0]         laneOn_ff;
    logic [NUM_LANES-1:0]         nxt_laneOn;

    for (genvar g = 0; g < NUM_LANES; g++) begin : gLane
        lane_pattern #(
            .LANE_IDX (g)
        ) uLane (
            .mode       (effMode),
            .sampleIs12 (sampleIs12),
            .octetIdx   (octetIdx_ff),
            .frameOdd   (frameOdd_ff),
            .rpatOctet  (rpatOctet),
            .normIn     (normLane[g]),
            .laneOut    (laneNext[g])
        );
    end

    always_comb begin
        for (int i = 0; i < NUM_LANES; i++) begin
            // Lane count comes from the link mode while linkEnable is high, whatever the test mode
            nxt_laneOn[i] = linkEnable && (5'(i) < linkModeLanes); // R16
            if (nxt_laneOn[i]) begin
                nxt_txLane[i] = laneNext[i];
            end else begin
                nxt_txLane[i] = '{data: 8'h00, ctrl: 1'b0}; // R6
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                txLane_ff[i] <= '{data: 8'h00, ctrl: 1'b0};
            end
            laneOn_ff <= '0;
        end else if (ce) begin
            txLane_ff <= nxt_txLane;
            laneOn_ff <= nxt_laneOn;
        end
    end

    assign txLane = txLane_ff;
    assign laneOn = laneOn_ff;

    // Link layer control
    logic ilasRepeat_ff;
    logic nxt_ilasRepeat;
    logic codeGroupSync_ff;
    logic nxt_codeGroupSync;
    logic patternActive_ff;
    logic nxt_patternActive;

    always_comb begin
        nxt_ilasRepeat    = (effMode == pattern_gen_pkg::MODE_REP_ILAS); // R10
        // The link layer runs code group sync and then resumes the repeated sequence
        nxt_codeGroupSync = nxt_ilasRepeat && syncRequest; // R11
        nxt_patternActive = (effMode != pattern_gen_pkg::MODE_NORMAL);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ilasRepeat_ff    <= 1'b0;
            codeGroupSync_ff <= 1'b0;
            patternActive_ff <= 1'b0;
        end else if (ce) begin
            ilasRepeat_ff    <= nxt_ilasRepeat;
            codeGroupSync_ff <= nxt_codeGroupSync;
            patternActive_ff <= nxt_patternActive;
        end
    end

    assign ilasRepeat    = ilasRepeat_ff;
    assign codeGroupSync = codeGroupSync_ff;
    assign patternActive = patternActive_ff;

endmodule

// ---- test/pattern_gen_monitor.sv ----
// Port checker of the test-pattern generator.
// Assumes it is bound to the generator and sees its ports only.
module pattern_gen_monitor #(
    parameter int NUM_LANES = 16
) (
    // Clock and reset
    input wire logic                         clk_sys,
    input wire logic                         rst_b,
    // Inputs
    input wire logic                         linkEnable,
    input wire logic                         enc64b66b,
    input wire logic [4:0]                   linkModeLanes,
    input wire logic                         syncRequest,
    input wire pattern_gen_pkg::lane_octet_t normLane [NUM_LANES],
    // Outputs
    input wire pattern_gen_pkg::lane_octet_t txLane [NUM_LANES],
    input wire logic [NUM_LANES-1:0]         laneOn,
    input wire logic                         ilasRepeat,
    input wire logic                         codeGroupSync,
    input wire logic                         patternActive
);
    logic [NUM_LANES-1:0] expOn;
    logic                 unusedBusy;
    always_comb begin
        expOn = '0;
        unusedBusy = 1'b0;
        for (int i = 0; i < NUM_LANES; i++) begin
            expOn[i] = (i < linkModeLanes);
            unusedBusy = unusedBusy | (!laneOn[i] && txLane[i] != '0);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_lanes_off: assert property (!linkEnable |=> laneOn == '0)
        else $error("lanes powered while link disabled");
    chk_lane_count: assert property (linkEnable |=> laneOn == $past(expOn))
        else $error("powered lanes differ from link mode");
    chk_unused_zero: assert property (!unusedBusy)
        else $error("unused lane carries data");
    chk_sync_follow: assert property ((ilasRepeat && syncRequest) ##1 ilasRepeat
        |-> codeGroupSync)
        else $error("sync request not followed by code group sync");
    chk_sync_cause: assert property (codeGroupSync |-> $past(syncRequest))
        else $error("code group sync without request");
    chk_no_ilas_64: assert property (enc64b66b ##1 enc64b66b |-> !ilasRepeat)
        else $error("alignment repeat under 64b66b");
    // Repeated alignment passes normal data through, so its octets are excluded here
    chk_k285_ctrl: assert property (patternActive && !ilasRepeat && txLane[0].ctrl
        |-> txLane[0].data == 8'hBC && !$past(enc64b66b))
        else $error("control character outside 8b10b comma mode");
    chk_rpat_step: assert property (patternActive && !ilasRepeat && txLane[0].data == 8'hBE
        ##1 patternActive |-> txLane[0].data == 8'hD7)
        else $error("jitter pattern order broken");
    chk_rpat_wrap: assert property (patternActive && !ilasRepeat && txLane[0].data == 8'h59
        ##1 patternActive |-> txLane[0].data == 8'hBE)
        else $error("jitter pattern does not wrap");
    chk_d215_hold: assert property (patternActive && !ilasRepeat && txLane[0].data == 8'hB5
        ##1 patternActive |-> txLane[0] == {8'hB5, 1'b0})
        else $error("alternating stream interrupted");
    chk_idle_pass: assert property (linkEnable
        ##1 (linkEnable && !patternActive && laneOn[0]) |-> txLane[0] == $past(normLane[0]))
        else $error("normal data not passed through");
    cover property (patternActive && txLane[0].data == 8'h59);
    cover property (codeGroupSync);
    cover property (patternActive && txLane[0].ctrl);
endmodule

bind serial_link_test_pattern_gen pattern_gen_monitor #(.NUM_LANES(NUM_LANES)) monitor (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .linkEnable    (linkEnable),
    .enc64b66b     (enc64b66b),
    .linkModeLanes (linkModeLanes),
    .syncRequest   (syncRequest),
    .normLane      (normLane),
    .txLane        (txLane),
    .laneOn        (laneOn),
    .ilasRepeat    (ilasRepeat),
    .codeGroupSync (codeGroupSync),
    .patternActive (patternActive)
);

// ---- test/link_receiver_model.sv ----
// Behavioural receiver at the far end of the lanes.
// Assumes the bench asks for resynchronisation through wantSync.
module link_receiver_model (
    // Clock
    input wire logic clk_sys,
    // Control
    input wire logic wantSync,
    input wire logic ilasRepeat,
    input wire logic codeGroupSync,
    output logic     syncRequest
);
    initial syncRequest = 1'b0;
    // Request held until answered, then raised again to keep the loop busy
    always @(posedge clk_sys) begin
        if (!wantSync || codeGroupSync)
            syncRequest <= 1'b0;
        else if (ilasRepeat)
            syncRequest <= 1'b1;
    end
endmodule

// ---- test/serial_link_test_pattern_gen_tb_top.sv ----
// Self-checking bench of the serial-link test-pattern generator.
// Assumes the package, generator, monitor and receiver model compile first.
module serial_link_test_pattern_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        pattern_gen_pkg::lane_octet_t [3:0] o;
        logic [15:0]                        on;
        logic                               il;
        logic                               cg;
        logic                               pa;
    } note_t;
    localparam int CHK [4] = '{0, 3, 5, 13};
    localparam logic [7:0] RPAT [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
                                         8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
    logic                         clk_sys = 1'b0;
    logic                         rst_b, ce, linkEnable, enc64b66b, sampleIs12;
    logic                         linkInDataEnc, serInitDone, syncRequest, wantSync;
    logic [2:0]                   testPatternSelect, msel;
    logic [3:0]                   frameOctets;
    logic [4:0]                   linkModeLanes;
    pattern_gen_pkg::lane_octet_t normLane [16];
    pattern_gen_pkg::lane_octet_t txLane [16];
    logic [15:0]                  laneOn;
    logic                         ilasRepeat, codeGroupSync, patternActive;
    logic [31:0]                  seed = 32'h0001_2A9F;
    logic [8:0]                   fx;
    int                           kind, pos, errors, checks_done;
    note_t                        notes [$];
    note_t                        nt;

    always #5 clk_sys = ~clk_sys;

    serial_link_test_pattern_gen #(.NUM_LANES(16)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .testPatternSelect(testPatternSelect),
        .linkEnable(linkEnable), .enc64b66b(enc64b66b), .sampleIs12(sampleIs12),
        .frameOctets(frameOctets), .linkModeLanes(linkModeLanes),
        .linkInDataEnc(linkInDataEnc), .serInitDone(serInitDone), .syncRequest(syncRequest),
        .normLane(normLane), .txLane(txLane), .laneOn(laneOn), .ilasRepeat(ilasRepeat),
        .codeGroupSync(codeGroupSync), .patternActive(patternActive));

    link_receiver_model rx (.clk_sys(clk_sys), .wantSync(wantSync), .ilasRepeat(ilasRepeat),
        .codeGroupSync(codeGroupSync), .syncRequest(syncRequest));

    function automatic logic [31:0] lfsrStep(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [3:0] nib(input int n, input int m);
        if (n == 15) return 4'h0;
        if (n % 3 == 0) return 4'(15 - m);
        if (n % 3 == 1) return 4'(m);
        return 4'(n / 3 + 1);
    endfunction

    function automatic pattern_gen_pkg::lane_octet_t expOct(input int l);
        int o;
        int fo;
        o = pos % 8;
        fo = (frameOctets == 4'h0) ? 1 : int'(frameOctets);
        if (!linkEnable || l >= int'(linkModeLanes)) return 9'h000;
        case (kind)
            1: if (sampleIs12) return {nib(2 * o, l % 8), nib(2 * o + 1, l % 8), 1'b0};
               else return {((pos / fo) % 2 == 1) ? ~8'(l % 4) : 8'(l % 4), 1'b0};
            2: return fx;
            3: return {RPAT[pos % 12], 1'b0};
            default: return normLane[l];
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One driven cycle: fresh normal data, note of what the next edge must show
    task automatic cyc(input int k);
        note_t n;
        kind = k;
        foreach (normLane[i]) begin
            seed = lfsrStep(seed);
            normLane[i] = seed[8:0];
        end
        foreach (CHK[i]) n.o[i] = expOct(CHK[i]);
        n.on = linkEnable ? 16'((32'h1 << linkModeLanes) - 1) : 16'h0000;
        n.il = linkEnable && msel == 3'h4 && !enc64b66b;
        // Request seen at this edge is answered at that same edge
        n.cg = n.il && syncRequest;
        n.pa = n.il || (linkEnable && k != 0);
        notes.push_back(n);
        if (k != 0) pos++;
        @(negedge clk_sys);
    endtask

    // Selection only moves while the link is down
    task automatic scen(input logic [2:0] s, input logic e, input logic w, input int k,
                        input int n);
        testPatternSelect = s;
        msel = s;
        enc64b66b = e;
        sampleIs12 = w;
        linkEnable = 1'b0;
        linkInDataEnc = 1'b0;
        serInitDone = 1'b0;
        cyc(0);
        linkEnable = 1'b1;
        linkInDataEnc = e;
        serInitDone = !e;
        if (k == 1) cyc(0);
        linkInDataEnc = 1'b1;
        serInitDone = 1'b1;
        pos = 0;
        repeat (n) cyc(k);
    endtask

    always @(posedge clk_sys) begin
        #1;
        if (notes.size() > 0) begin
            nt = notes.pop_front();
            foreach (CHK[i]) check("txLane", 16'(txLane[CHK[i]]), 16'(nt.o[i]));
            check("laneOn", laneOn, nt.on);
            check("ilasRepeat", 16'(ilasRepeat), 16'(nt.il));
            check("codeGroupSync", 16'(codeGroupSync), 16'(nt.cg));
            check("patternActive", 16'(patternActive), 16'(nt.pa));
        end
    end

    initial begin
        #1ms;
        errors++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        wantSync = 1'b0;
        frameOctets = 4'h1;
        linkModeLanes = 5'h06;
        testPatternSelect = 3'h0;
        msel = 3'h0;
        {linkEnable, enc64b66b, sampleIs12, linkInDataEnc, serInitDone} = 5'h00;
        fx = 9'h16A;
        pos = 0;
        repeat (12) cyc(0);
        rst_b = 1'b1;
        scen(3'h0, 1'b0, 1'b0, 0, 6);
        scen(3'h1, 1'b0, 1'b0, 1, 9);
        frameOctets = 4'h0;
        scen(3'h1, 1'b0, 1'b0, 1, 4);
        frameOctets = 4'h2;
        scen(3'h1, 1'b1, 1'b0, 1, 9);
        linkModeLanes = 5'h0E;
        scen(3'h1, 1'b1, 1'b1, 1, 18);
        scen(3'h2, 1'b1, 1'b0, 2, 5);
        scen(3'h3, 1'b1, 1'b0, 0, 4);
        fx = 9'h179;
        scen(3'h3, 1'b0, 1'b0, 2, 5);
        scen(3'h5, 1'b1, 1'b0, 0, 4);
        scen(3'h5, 1'b0, 1'b0, 3, 14);
        testPatternSelect = 3'h2;
        repeat (4) cyc(3);
        wantSync = 1'b1;
        scen(3'h4, 1'b0, 1'b0, 0, 12);
        scen(3'h4, 1'b1, 1'b0, 0, 4);
        wantSync = 1'b0;
        scen(3'h7, 1'b0, 1'b0, 0, 4);
        linkEnable = 1'b0;
        repeat (2) cyc(0);
        summarize();
    end
endmodule
